// ---- verilog/tcc_codec.sv ----
/*
 * Character path of a tape control unit: longitudinal parity, clock
 * detect handshake, registers-full and overrun, code translation.
 * Assumes all inputs come from logic on clk, and that the gate and
 * detect pulses each last at least one clock.
 */
// Notes on behaviour
// - In read, each gate-read pulse toggles write data bits where the character has ones.
// - Operation start clears the write data register.
// - Falling gate-read in read mode sets clock detect if not already set.
// - Clock detect set tells the host a character waits in the buffer.
// - Host acknowledge stage clears clock detect while accept stage is down and registers full is clear.
// - Gate-read while clock detect is set sets registers full.
// - While full, the character stays in read flops until host accept.
// - Host accept clears registers full, moves the character, keeps clock detect.
// - Detect period with both flags set fires the error pulse.
// - Data mode flag set selects decimal, cleared selects binary.
// - Decimal characters are recorded with even parity, binary with the host's own parity bit.
// - Decimal output passes bits 6, 4, 2; translates bits 5, 3, 1, parity.
// - Binary output copies every host bit unchanged.
// - Decimal input converts interchange code to host code.
// - Binary input delivers buffer bits unchanged.
// - After a record, any set write data bit flags a longitudinal error.
// - Host 00 maps to tape 12; zones 2x/3x and 6x/7x swap.
module tcc_codec
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operation control
    input wire logic op_start,
    input wire logic tape_unit_selected,
    input wire logic write_direction,
    input wire logic data_mode_flag,
    // Tape read timing and data
    input wire logic char_gate_read,
    input wire logic char_detect_clock,
    input wire logic [CHAR_W-1:0] tape_char,
    input wire logic lrc_check,
    // Host buffer handshake
    input wire logic host_accept_stage,
    input wire logic host_ack_stage,
    input wire logic [CHAR_W-1:0] host_char_register,
    input wire logic host_char_load,
    // Results
    output logic char_waiting,
    output logic regs_full,
    output logic host_error,
    output logic lrc_error,
    output logic [CHAR_W-1:0] write_data_register,
    output logic [CHAR_W-1:0] host_char_out
);
    logic cr_q;
    logic cf_q;
    logic [CHAR_W-1:0] read_flops;
    logic [CHAR_W-1:0] buffer_register;

    tcc_char_if xout ();
    tcc_char_if xin ();

    tcc_xlate #(.TO_TAPE(1'b1)) u_out (.ch(xout.xlate));
    tcc_xlate #(.TO_TAPE(1'b0)) u_in (.ch(xin.xlate));

    assign xout.raw = host_char_register;
    assign xout.decimal = data_mode_flag;
    assign xin.raw = buffer_register;
    assign xin.decimal = data_mode_flag;

    logic read_mode;
    logic write_mode;
    logic cr_fall;
    logic cf_rise;
    logic take_char;
    logic ack_clear;
    logic promote;
    logic buf_free;
    logic flops_free;
    logic load_flops;
    logic overrun;
    logic out_load;

    assign read_mode = tape_unit_selected & ~write_direction;
    assign write_mode = tape_unit_selected & write_direction;
    assign cr_fall = cr_q & ~char_gate_read;
    assign cf_rise = char_detect_clock & ~cf_q;
    assign take_char = read_mode & cr_fall & ~op_start;
    // Acknowledge only counts while the accept stage is down and no second char
    assign ack_clear = char_waiting & host_ack_stage & ~host_accept_stage
                       & ~regs_full;
    assign promote = read_mode & regs_full & host_accept_stage & ~op_start;
    assign buf_free = ~char_waiting | ack_clear;
    assign flops_free = ~regs_full | promote;
    assign load_flops = take_char & ~buf_free & flops_free;
    // A third char with both stores full is lost; only the error reports it
    assign overrun = read_mode & cf_rise & char_waiting & regs_full & ~op_start;
    assign out_load = write_mode & host_char_load & ~op_start;

    logic next_char_waiting;
    logic next_regs_full;
    logic [CHAR_W-1:0] next_wdr;

    // Set wins over the clear when both land in one cycle
    assign next_char_waiting = op_start ? 1'b0
                             : (take_char & buf_free) ? 1'b1
                             : ack_clear ? 1'b0
                             : char_waiting;
    assign next_regs_full = op_start ? 1'b0
                          : load_flops ? 1'b1
                          : promote ? 1'b0
                          : regs_full;
    assign next_wdr = op_start ? CHAR_RESET
                    : take_char ? (write_data_register ^ tape_char)
                    : out_load ? xout.cooked
                    : write_data_register;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cr_q <= 1'b0;
            cf_q <= 1'b0;
            char_waiting <= 1'b0;
            regs_full <= 1'b0;
            write_data_register <= CHAR_RESET;
        end
        else
        begin
            cr_q <= char_gate_read;
            cf_q <= char_detect_clock;
            char_waiting <= next_char_waiting;
            regs_full <= next_regs_full;
            write_data_register <= next_wdr;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_flops <= CHAR_RESET;
            buffer_register <= CHAR_RESET;
        end
        else if (op_start)
        begin
            read_flops <= CHAR_RESET;
            buffer_register <= CHAR_RESET;
        end
        else
        begin
            if (load_flops)
                read_flops <= tape_char;
            if (promote)
                buffer_register <= read_flops;
            else if (take_char & buf_free)
                buffer_register <= tape_char;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_error <= 1'b0;
            lrc_error <= 1'b0;
            host_char_out <= CHAR_RESET;
        end
        else
        begin
            host_error <= overrun;
            if (op_start)
                lrc_error <= 1'b0;
            else if (lrc_check & read_mode & (|write_data_register))
                lrc_error <= 1'b1;
            host_char_out <= xin.cooked;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_both_full;
        read_mode && cf_rise && char_waiting && regs_full && !op_start;
    endsequence

    sequence s_error_pulse;
        host_error ##1 !host_error;
    endsequence

    a_lrc_toggle: assert property (take_char |=>
        write_data_register == ($past(write_data_register) ^ $past(tape_char)))
        else $error("parity accumulation wrong");
    a_start_clears: assert property (op_start |=>
        write_data_register == CHAR_RESET && !char_waiting && !regs_full)
        else $error("start did not clear state");
    a_detect_set: assert property (take_char && !char_waiting |=>
        char_waiting && buffer_register == $past(tape_char))
        else $error("clock detect not set");
    a_ack_clears: assert property (ack_clear && !take_char && !op_start |=>
        !char_waiting)
        else $error("acknowledge did not clear clock detect");
    // A start pulse right after the set clears the flag legally
    a_full_set: assert property (take_char && char_waiting && !ack_clear
        && !regs_full |=> (regs_full && read_flops == $past(tape_char))
        ##1 (regs_full || $past(promote) || $past(op_start)))
        else $error("registers full not held");
    a_promote: assert property (promote && !take_char |=>
        !regs_full && char_waiting && buffer_register == $past(read_flops))
        else $error("accept did not move character");
    a_overrun_err: assert property (s_both_full |=> s_error_pulse)
        else $error("overrun error pulse missing");
    a_out_decimal: assert property (out_load && data_mode_flag &&
        host_char_register[CHAR_W-1:1] == CODE_CLEAR |=> write_data_register == TAPE_ZERO_CHAR)
        else $error("decimal zero not translated");
    a_out_binary: assert property (out_load && !data_mode_flag |=>
        write_data_register == $past(host_char_register))
        else $error("binary output altered");
    a_lrc_flag: assert property (lrc_check && read_mode && !op_start &&
        write_data_register != CHAR_RESET |=> lrc_error)
        else $error("longitudinal error missed");
endmodule : tcc_codec

// ---- verilog/tcc_pkg.sv ----
/*
 * Shared constants of the tape character codec: character layout,
 * code values and reset values.
 * Assumes a 7-bit character, index 0 parity, index 1..6 data bits 1..6,
 * with data bit 1 the most significant bit of the octal code.
 */
package tcc_pkg;
    localparam int CHAR_W = 7;
    localparam int CODE_W = 6;
    localparam int BIT_P = 0;
    localparam int BIT_1 = 1;
    localparam int BIT_2 = 2;
    localparam int BIT_3 = 3;
    localparam int BIT_4 = 4;
    localparam int BIT_5 = 5;
    localparam int BIT_6 = 6;
    localparam int CODE_ZONE_LO = 4;
    localparam logic [CODE_W-1:0] HOST_ZERO = 6'h00;
    localparam logic [CODE_W-1:0] TAPE_ZERO = 6'h0a;
    localparam logic [CODE_W-1:0] ZONE_FLIP = 6'h20;
    localparam logic [CODE_W-1:0] CODE_CLEAR = 6'h00;
    localparam logic [CHAR_W-1:0] CHAR_RESET = 7'h00;
    localparam logic [CHAR_W-1:0] TAPE_ZERO_CHAR = 7'h28;
endpackage : tcc_pkg

// ---- verilog/tcc_char_if.sv ----
/*
 * Interface carrying one character through a code translator.
 * Assumes the user side drives raw and decimal on the same clock.
 */
interface tcc_char_if;
    import tcc_pkg::*;
    logic [CHAR_W-1:0] raw;
    logic [CHAR_W-1:0] cooked;
    logic decimal;
    modport xlate (input raw, input decimal, output cooked);
    modport user (output raw, output decimal, input cooked);
endinterface : tcc_char_if

// ---- verilog/tcc_xlate.sv ----
/*
 * Combinational translator between host internal code and decimal
 * interchange code, one direction per instance.
 * Assumes the caller registers the result.
 */
module tcc_xlate
    import tcc_pkg::*;
#(
    parameter bit TO_TAPE = 1'b1
)
(
    tcc_char_if.xlate ch
);
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] swapped;
    logic [CODE_W-1:0] mapped;
    logic data_xor;
    logic dec_parity;
    logic [CHAR_W-1:0] dec_char;

    // Bit 1 is the top octal bit, so the code reads bits 1 to 6
    assign code = {ch.raw[BIT_1], ch.raw[BIT_2], ch.raw[BIT_3],
                   ch.raw[BIT_4], ch.raw[BIT_5], ch.raw[BIT_6]};
    // Zones 2x/3x and 6x/7x trade places: flip bit 1 when bit 2 is set
    assign swapped = code[CODE_ZONE_LO] ? (code ^ ZONE_FLIP) : code;
    assign mapped = TO_TAPE ? ((code == HOST_ZERO) ? TAPE_ZERO : swapped)
                            : ((code == TAPE_ZERO) ? HOST_ZERO : swapped);
    assign data_xor = ^mapped;
    // Tape side gets even parity; host side always sees odd parity
    assign dec_parity = TO_TAPE ? data_xor : ~data_xor;
    // Bits 6, 4 and 2 never change under the mapping above
    assign dec_char = {mapped[0], mapped[1], mapped[2], mapped[3],
                       mapped[4], mapped[5], dec_parity};
    assign ch.cooked = ch.decimal ? dec_char : ch.raw;
endmodule : tcc_xlate

// ---- testbench/tcc_host_model.sv ----
/*
 * Host word buffer model answering the clock-detect handshake.
 * Assumes the codec shares clk; stall holds both stages low.
 */
module tcc_host_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Codec status and test control
    input wire logic char_waiting,
    input wire logic regs_full,
    input wire logic stall,
    // Handshake stages
    output logic host_ack_stage,
    output logic host_accept_stage
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_ack_stage <= 1'b0;
            host_accept_stage <= 1'b0;
        end
        else
        begin
            // Ack only with nothing stacked behind, else it would be ignored
            host_ack_stage <= char_waiting && !regs_full && !stall && !host_ack_stage;
            host_accept_stage <= regs_full && !stall && !host_accept_stage;
        end
    end
endmodule : tcc_host_model

// ---- testbench/tcc_codec_tb.sv ----
/*
 * Self-checking bench of the tape character codec.
 * Assumes the host model answers the handshake on the same clock.
 */
module tcc_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, op_start, tape_unit_selected, write_direction, data_mode_flag;
    logic char_gate_read, char_detect_clock, lrc_check, host_char_load, stall;
    logic host_accept_stage, host_ack_stage, char_waiting, regs_full, host_error, lrc_error;
    logic [6:0] tape_char, host_char_register, write_data_register, host_char_out;
    logic load_seen = 1'b0, cmp_host = 1'b0, prev_cw = 1'b0, prev_rf = 1'b0;
    logic [6:0] q_host[$], q_wdr[$], exp_note;
    // Zero, zone edges and the tape zero code
    logic [6:0] dir[6] = '{7'h00, 7'h04, 7'h06, 7'h28, 7'h7c, 7'h7e};
    int errors = 0, num_checks = 0;
    tcc_codec tcc_codec_i (.clk(clk), .rst_n(rst_n), .op_start(op_start),
        .tape_unit_selected(tape_unit_selected), .write_direction(write_direction),
        .data_mode_flag(data_mode_flag), .char_gate_read(char_gate_read),
        .char_detect_clock(char_detect_clock), .tape_char(tape_char), .lrc_check(lrc_check),
        .host_accept_stage(host_accept_stage), .host_ack_stage(host_ack_stage),
        .host_char_register(host_char_register), .host_char_load(host_char_load),
        .char_waiting(char_waiting), .regs_full(regs_full), .host_error(host_error),
        .lrc_error(lrc_error), .write_data_register(write_data_register),
        .host_char_out(host_char_out));
    tcc_host_model tcc_host_model_i (.clk(clk), .rst_n(rst_n), .char_waiting(char_waiting),
        .regs_full(regs_full), .stall(stall), .host_ack_stage(host_ack_stage),
        .host_accept_stage(host_accept_stage));
    function automatic logic [6:0] xlate(input logic [6:0] ch, input logic dm, input logic out);
        logic [5:0] c;
        logic [6:0] r;
        for (int i = 1; i < 7; i++) c[6-i] = ch[i];
        if (c == (out ? 6'h00 : 6'h0a))
            c = out ? 6'h0a : 6'h00;
        else if (c[4])
            c[5] = !c[5];
        for (int i = 1; i < 7; i++) r[i] = c[6-i];
        r[0] = (^r[6:1]) ^ !out;
        return dm ? r : ch;
    endfunction : xlate
    task automatic check(input string name, input logic [6:0] exp, input logic [6:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic start_op(input logic wr, input logic dm);
        write_direction = wr;
        data_mode_flag = dm;
        op_start = 1'b1;
        @(negedge clk);
        op_start = 1'b0;
        @(negedge clk);
        check("write_data_register", 7'h00, write_data_register);
    endtask : start_op
    task automatic send_char(input logic [6:0] c, input logic keep);
        char_gate_read = 1'b1;
        @(negedge clk);
        char_gate_read = 1'b0;
        tape_char = c;
        if (keep)
            q_host.push_back(xlate(c, data_mode_flag, 1'b0));
        @(negedge clk);
        tape_char = ~c;
    endtask : send_char
    task automatic detect_pulse(input int exp_n);
        int n;
        n = 0;
        char_detect_clock = 1'b1;
        repeat (4)
        begin
            @(negedge clk);
            if (host_error === 1'b1)
                n++;
        end
        char_detect_clock = 1'b0;
        @(negedge clk);
        check("host_error pulses", 7'(exp_n), 7'(n));
    endtask : detect_pulse
    task automatic read_record(input logic dm, input logic fix);
        logic [6:0] acc;
        logic [6:0] c;
        acc = 7'h00;
        start_op(1'b0, dm);
        for (int i = 0; i < 10; i++)
        begin
            c = (i < 6) ? dir[i] : 7'($urandom);
            if (fix && i == 9)
                c = acc;
            send_char(c, 1'b1);
            acc ^= c;
            repeat (3) @(negedge clk);
        end
        lrc_check = 1'b1;
        @(negedge clk);
        lrc_check = 1'b0;
        @(negedge clk);
        check("write_data_register", acc, write_data_register);
        check("lrc_error", {6'h00, acc != 7'h00}, {6'h00, lrc_error});
    endtask : read_record
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) load_seen <= host_char_load && write_direction;
    // Scoreboard side: a result shows a cycle after the flag that announces it
    always @(negedge clk)
    begin
        if (cmp_host)
        begin
            exp_note = q_host.size() ? q_host.pop_front() : 7'hxx;
            check("host_char_out", exp_note, host_char_out);
        end
        if (load_seen)
        begin
            exp_note = q_wdr.size() ? q_wdr.pop_front() : 7'hxx;
            check("write_data_register", exp_note, write_data_register);
        end
        cmp_host = (char_waiting && !prev_cw) || (prev_rf && !regs_full);
        prev_cw = char_waiting;
        prev_rf = regs_full;
    end
    initial
    begin
        #(25 * 8000);
        errors++;
        print_verdict();
    end
    initial
    begin
        {op_start, write_direction, data_mode_flag, char_gate_read, char_detect_clock} = '0;
        {lrc_check, host_char_load, stall, rst_n} = '0;
        tape_unit_selected = 1'b1;
        tape_char = 7'h00;
        host_char_register = 7'h00;
        void'($urandom(32));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            start_op(1'b1, m[0]);
            // Loads back to back, the tightest spacing allowed
            for (int i = 0; i < 10; i++)
            begin
                host_char_register = (i < 6) ? dir[i] : 7'($urandom);
                host_char_load = 1'b1;
                q_wdr.push_back(xlate(host_char_register, m[0], 1'b1));
                @(negedge clk);
            end
            host_char_load = 1'b0;
            @(negedge clk);
        end
        for (int m = 0; m < 4; m++) read_record(m[0], m[1]);
        start_op(1'b0, 1'b1);
        // Deselected unit: a gate pulse must reach neither flags nor accumulator
        tape_unit_selected = 1'b0;
        send_char(dir[4], 1'b0);
        check("char_waiting", 7'h00, {6'h00, char_waiting});
        check("write_data_register", 7'h00, write_data_register);
        tape_unit_selected = 1'b1;
        stall = 1'b1;
        send_char(dir[3], 1'b1);
        detect_pulse(0);
        send_char(dir[1], 1'b1);
        @(negedge clk);
        check("full_waiting", 7'h03, {5'h00, regs_full, char_waiting});
        detect_pulse(1);
        send_char(dir[2], 1'b0);
        check("host_char_out", xlate(dir[3], 1'b1, 1'b0), host_char_out);
        stall = 1'b0;
        repeat (8) @(negedge clk);
        check("full_waiting", 7'h00, {5'h00, regs_full, char_waiting});
        check("pending", 7'h00, 7'(q_host.size() + q_wdr.size()));
        print_verdict();
    end
endmodule : tcc_codec_tb
